// ==== vbi_data_inserter.sv ====
// Purpose: inserts copy control, signaling and caption data on blank lines
// Assumes: line_start pulses at the falling horizontal sync edge
// Notes: serial element stream on ins_bit, analog shaping done downstream
`timescale 1ns/1ps
`default_nettype none
//
// How it works
// - 525p with CGMS enabled sends the three-byte CGMS word on line 41.
// - 525p with Type B enabled sends the Type B packet on line 40.
// - 625p with CGMS enabled sends only the low 14 CGMS bits on line 43.
// - 720p with CGMS enabled sends the CGMS word on line 24.
// - 1080i with CGMS enabled sends the CGMS word on lines 19 and 582.
// - 720p with Type B enabled sends the packet on line 23.
// - 1080i with Type B enabled sends the packet on lines 18 and 581.
// - with a CGMS check enable set, top six bits are computed from the low 14.
// - check generators use x^6+x+1, preset to all ones per word.
// - with CGMS check off, all twenty bits come straight from registers.
// - with Type B check on, P122..P127 derive from the first 128 bits.
// - with Type B check off, all 134 bits come straight from registers.
// - a 14-bit signaling word goes on line 23, only in PAL.
// - run-in and start code precede it; video returns 42.5 us after sync.
// - signaling sent only when its enable is set; blank bit blanks it.
// - signaling word field layout fixed; bit 7 always sent as zero.
// - captions go on line 21 of odd fields and 284 of even fields.
// - caption line: 7-cycle run-in, two blank bits, start one, 16 bits.
// - line 21 bytes from the caption pair, line 284 from the extended pair.
// - caption lines are generated internally, pixel input is ignored.
module vbi_data_inserter #(
  parameter logic [13:0] WSS_VIDEO_CYC = 14'(vbi_pkg::WSS_VIDEO_CYC)
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // subaddress register port
  input wire logic reg_we,
  input wire logic reg_re,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // timing generator
  input wire vbi_pkg::vbi_std_e vid_std,
  input wire logic line_start,
  input wire logic [10:0] line_num,
  input wire logic field_odd,
  input wire logic cc_enable,
  // inserted data
  output logic ins_active,
  output logic ins_bit,
  output logic pix_blank
);

  typedef enum {SQ_IDLE, SQ_LEAD, SQ_SEND} vbi_seq_e;
  typedef enum logic [2:0] {
    KD_NONE, KD_CGMS, KD_TB, KD_WSS, KD_CC, KD_WBLANK
  } vbi_kind_e;

  logic [7:0] prog_ctrl_reg;
  logic [7:0] cgms0_reg;
  logic [7:0] cgms1_reg;
  logic [7:0] cgms2_reg;
  logic [7:0] typeb_reg [vbi_pkg::TYPEB_BYTES];
  logic [7:0] ccx0_reg;
  logic [7:0] ccx1_reg;
  logic [7:0] cc0_reg;
  logic [7:0] cc1_reg;
  logic [7:0] sd_sig_reg;
  logic [7:0] wss0_reg;
  logic [7:0] wss1_reg;
  logic [7:0] sd_blank_reg;
  logic [7:0] rd_next;

  ////////////////////////////////////////////////////////////////////////
  // register writes
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      prog_ctrl_reg <= vbi_pkg::REG_RST;
      cgms0_reg <= vbi_pkg::REG_RST;
      cgms1_reg <= vbi_pkg::REG_RST;
      cgms2_reg <= vbi_pkg::REG_RST;
      for (int i = 0; i < vbi_pkg::TYPEB_BYTES; i++)
      begin
        typeb_reg[i] <= vbi_pkg::REG_RST;
      end
      ccx0_reg <= vbi_pkg::REG_RST;
      ccx1_reg <= vbi_pkg::REG_RST;
      cc0_reg <= vbi_pkg::REG_RST;
      cc1_reg <= vbi_pkg::REG_RST;
      sd_sig_reg <= vbi_pkg::REG_RST;
      wss0_reg <= vbi_pkg::REG_RST;
      wss1_reg <= vbi_pkg::REG_RST;
      sd_blank_reg <= vbi_pkg::REG_RST;
    end
    else if (ce && reg_we)
    begin
      if (reg_addr >= vbi_pkg::OFF_TYPEB_FIRST &&
          reg_addr <= vbi_pkg::OFF_TYPEB_LAST)
      begin
        typeb_reg[5'(reg_addr - vbi_pkg::OFF_TYPEB_FIRST)] <= reg_wdata;
      end
      unique case (reg_addr)
        vbi_pkg::OFF_PROG_CTRL: prog_ctrl_reg <= reg_wdata;
        vbi_pkg::OFF_CGMS0: cgms0_reg <= reg_wdata;
        vbi_pkg::OFF_CGMS1: cgms1_reg <= reg_wdata;
        vbi_pkg::OFF_CGMS2: cgms2_reg <= reg_wdata;
        vbi_pkg::OFF_CCX0: ccx0_reg <= reg_wdata;
        vbi_pkg::OFF_CCX1: ccx1_reg <= reg_wdata;
        vbi_pkg::OFF_CC0: cc0_reg <= reg_wdata;
        vbi_pkg::OFF_CC1: cc1_reg <= reg_wdata;
        vbi_pkg::OFF_SD_SIG: sd_sig_reg <= reg_wdata;
        vbi_pkg::OFF_WSS0: wss0_reg <= reg_wdata;
        vbi_pkg::OFF_WSS1: wss1_reg <= reg_wdata;
        vbi_pkg::OFF_SD_BLANK: sd_blank_reg <= reg_wdata;
        default: ;
      endcase
    end
  end

  // read mux, unmapped subaddresses read zero
  always_comb
  begin
    rd_next = 8'h00;
    if (reg_addr >= vbi_pkg::OFF_TYPEB_FIRST &&
        reg_addr <= vbi_pkg::OFF_TYPEB_LAST)
    begin
      rd_next = typeb_reg[5'(reg_addr - vbi_pkg::OFF_TYPEB_FIRST)];
    end
    unique case (reg_addr)
      vbi_pkg::OFF_PROG_CTRL: rd_next = prog_ctrl_reg;
      vbi_pkg::OFF_CGMS0: rd_next = cgms0_reg;
      vbi_pkg::OFF_CGMS1: rd_next = cgms1_reg;
      vbi_pkg::OFF_CGMS2: rd_next = cgms2_reg;
      vbi_pkg::OFF_CCX0: rd_next = ccx0_reg;
      vbi_pkg::OFF_CCX1: rd_next = ccx1_reg;
      vbi_pkg::OFF_CC0: rd_next = cc0_reg;
      vbi_pkg::OFF_CC1: rd_next = cc1_reg;
      vbi_pkg::OFF_SD_SIG: rd_next = sd_sig_reg;
      vbi_pkg::OFF_WSS0: rd_next = wss0_reg;
      vbi_pkg::OFF_WSS1: rd_next = wss1_reg;
      vbi_pkg::OFF_SD_BLANK: rd_next = sd_blank_reg;
      default: ;
    endcase
  end

  // registered read data, one cycle after the read strobe
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      reg_rdata <= 8'h00;
    else if (ce && reg_re)
      reg_rdata <= rd_next;
  end

  ////////////////////////////////////////////////////////////////////////
  // payload assembly
  logic cgms_en;
  logic tb_en;
  logic [19:0] cgms_raw;
  logic [5:0] cgms_crc;
  logic [19:0] cgms_word;
  logic [133:0] tb_raw;
  logic [5:0] tb_crc;
  logic [133:0] tb_pkt;
  logic [13:0] wss_word;
  logic [7:0] cc_b0;
  logic [7:0] cc_b1;
  logic [18:0] cc_bits;
  logic [37:0] cc_dbl;

  assign cgms_en = prog_ctrl_reg[vbi_pkg::BIT_CGMS_EN];
  assign tb_en = typeb_reg[0][vbi_pkg::BIT_TB_EN];
  assign cgms_raw = {cgms0_reg[3:0], cgms1_reg, cgms2_reg};

  // check bits over C13..C0
  vbi_crc6 #(.MSG_W(14)) u_cgms_crc (
    .msg(cgms_raw[13:0]),
    .crc(cgms_crc)
  );
  assign cgms_word = (prog_ctrl_reg[vbi_pkg::BIT_CGMS_CRC] ||
                      sd_sig_reg[vbi_pkg::BIT_SD_CRC]) ?
                     {cgms_crc, cgms_raw[13:0]} : cgms_raw;

  // packet packing: H0..H5 from the control byte, P bits from the rest
  assign tb_raw[5:0] = typeb_reg[0][7:2];
  for (genvar g = 1; g < vbi_pkg::TYPEB_BYTES; g++)
  begin : g_tb
    assign tb_raw[6 + 8 * (g - 1) +: 8] = typeb_reg[g];
  end
  vbi_crc6 #(.MSG_W(128)) u_tb_crc (
    .msg(tb_raw[127:0]),
    .crc(tb_crc)
  );
  assign tb_pkt = typeb_reg[0][vbi_pkg::BIT_TB_CRC] ?
                  {tb_crc, tb_raw[127:0]} : tb_raw;

  // signaling word, reserved bit forced low
  assign wss_word = {wss1_reg[5:0], 1'b0, wss0_reg[6:0]};

  // caption bytes per field, parity made odd over each byte
  assign cc_b0 = field_odd ? cc0_reg : ccx0_reg;
  assign cc_b1 = field_odd ? cc1_reg : ccx1_reg;
  assign cc_bits = {~^cc_b1[6:0], cc_b1[6:0],
                    ~^cc_b0[6:0], cc_b0[6:0], 3'b100};
  for (genvar g = 0; g < 19; g++)
  begin : g_cc
    assign cc_dbl[2 * g +: 2] = {cc_bits[g], cc_bits[g]};
  end

  ////////////////////////////////////////////////////////////////////////
  // line selection at line start
  vbi_kind_e sel_kind;
  logic [7:0] sel_len;
  logic [7:0] sel_per;
  logic [vbi_pkg::FRAME_W-1:0] sel_bits;

  always_comb
  begin
    sel_kind = KD_NONE;
    sel_len = 8'h00;
    sel_per = 8'h00;
    sel_bits = '0;
    if (cgms_en && ((vid_std == vbi_pkg::STD_525P &&
         line_num == vbi_pkg::LN_525P_CGMS) ||
        (vid_std == vbi_pkg::STD_720P &&
         line_num == vbi_pkg::LN_720P_CGMS) ||
        (vid_std == vbi_pkg::STD_1080I &&
         (line_num == vbi_pkg::LN_1080I_CGMS_A ||
          line_num == vbi_pkg::LN_1080I_CGMS_B))))
    begin
      sel_kind = KD_CGMS;
      sel_len = vbi_pkg::LEN_CGMS;
      sel_per = vbi_pkg::PER_CGMS;
      sel_bits[19:0] = cgms_word;
    end
    else if (cgms_en && vid_std == vbi_pkg::STD_625P &&
             line_num == vbi_pkg::LN_625P_CGMS)
    begin
      sel_kind = KD_CGMS;
      sel_len = vbi_pkg::LEN_CGMS_625;
      sel_per = vbi_pkg::PER_CGMS;
      sel_bits[13:0] = {cgms1_reg[5:0], cgms2_reg};
    end
    else if (tb_en && ((vid_std == vbi_pkg::STD_525P &&
              line_num == vbi_pkg::LN_525P_TB) ||
             (vid_std == vbi_pkg::STD_720P &&
              line_num == vbi_pkg::LN_720P_TB) ||
             (vid_std == vbi_pkg::STD_1080I &&
              (line_num == vbi_pkg::LN_1080I_TB_A ||
               line_num == vbi_pkg::LN_1080I_TB_B))))
    begin
      sel_kind = KD_TB;
      sel_len = vbi_pkg::LEN_TB;
      sel_per = vbi_pkg::PER_TB;
      sel_bits[133:0] = tb_pkt;
    end
    else if (vid_std == vbi_pkg::STD_PAL && line_num == vbi_pkg::LN_WSS)
    begin
      if (sd_blank_reg[vbi_pkg::BIT_WSS_BLANK])
        sel_kind = KD_WBLANK;
      else if (sd_sig_reg[vbi_pkg::BIT_WSS_EN])
      begin
        sel_kind = KD_WSS;
        sel_len = vbi_pkg::LEN_WSS;
        sel_per = vbi_pkg::PER_WSS;
        sel_bits[66:0] = {wss_word, vbi_pkg::WSS_START,
                          vbi_pkg::WSS_RUNIN};
      end
    end
    else if (cc_enable && vid_std == vbi_pkg::STD_NTSC &&
             ((field_odd && line_num == vbi_pkg::LN_CC_ODD) ||
              (!field_odd && line_num == vbi_pkg::LN_CC_EVEN)))
    begin
      sel_kind = KD_CC;
      sel_len = vbi_pkg::LEN_CC;
      sel_per = vbi_pkg::PER_CC;
      sel_bits[51:0] = {cc_dbl, vbi_pkg::CC_RUNIN};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // line timer, saturates at the top
  logic [13:0] line_cyc_reg;
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      line_cyc_reg <= 14'h0000;
    else if (ce && line_start)
      line_cyc_reg <= 14'h0000;
    else if (ce && line_cyc_reg != 14'h3fff)
      line_cyc_reg <= line_cyc_reg + 14'h0001;
  end

  // element sequencer
  vbi_seq_e seq_reg;
  vbi_kind_e kind_reg;
  logic [7:0] len_reg;
  logic [7:0] per_reg;
  logic [7:0] per_cnt_reg;
  logic [7:0] bit_cnt_reg;
  logic [vbi_pkg::FRAME_W-1:0] shift_reg;
  logic elem_end;

  assign elem_end = per_cnt_reg == per_reg - 8'h01;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      seq_reg <= SQ_IDLE;
      kind_reg <= KD_NONE;
      len_reg <= 8'h00;
      per_reg <= 8'h00;
      per_cnt_reg <= 8'h00;
      bit_cnt_reg <= 8'h00;
      shift_reg <= '0;
      ins_active <= 1'b0;
      ins_bit <= 1'b0;
    end
    else if (ce && line_start)
    begin
      kind_reg <= sel_kind;
      len_reg <= sel_len;
      per_reg <= sel_per;
      shift_reg <= sel_bits;
      seq_reg <= (sel_len != 8'h00) ? SQ_LEAD : SQ_IDLE;
      ins_active <= 1'b0;
      ins_bit <= 1'b0;
    end
    else if (ce)
    begin
      unique case (seq_reg)
        SQ_IDLE: ;
        SQ_LEAD:
          if (line_cyc_reg == vbi_pkg::START_CYC)
          begin
            seq_reg <= SQ_SEND;
            ins_active <= 1'b1;
            ins_bit <= shift_reg[0];
            shift_reg <= shift_reg >> 1;
            per_cnt_reg <= 8'h00;
            bit_cnt_reg <= 8'h00;
          end
        SQ_SEND:
          if (!elem_end)
            per_cnt_reg <= per_cnt_reg + 8'h01;
          else if (bit_cnt_reg == len_reg - 8'h01)
          begin
            seq_reg <= SQ_IDLE;
            ins_active <= 1'b0;
            ins_bit <= 1'b0;
          end
          else
          begin
            per_cnt_reg <= 8'h00;
            bit_cnt_reg <= bit_cnt_reg + 8'h01;
            ins_bit <= shift_reg[0];
            shift_reg <= shift_reg >> 1;
          end
      endcase
    end
  end

  // pixel blanking: whole caption line, signaling line until video returns
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      pix_blank <= 1'b0;
    else if (ce && line_start)
      pix_blank <= sel_kind != KD_NONE;
    else if (ce && (kind_reg == KD_WSS || kind_reg == KD_WBLANK))
    begin
      if (line_cyc_reg == WSS_VIDEO_CYC - 14'h0001)
        pix_blank <= 1'b0;
    end
    else if (ce && (kind_reg == KD_CGMS || kind_reg == KD_TB))
    begin
      if (seq_reg == SQ_SEND && elem_end && bit_cnt_reg == len_reg - 8'h01)
        pix_blank <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_load(logic hit);
    ce && line_start && hit;
  endsequence

  a_cgms_525_line: assert property (
    s_load(vid_std == vbi_pkg::STD_525P && cgms_en &&
           line_num == vbi_pkg::LN_525P_CGMS)
    |=> kind_reg == KD_CGMS && len_reg == vbi_pkg::LEN_CGMS)
    else $error("525p cgms not loaded on its line");
  a_tb_525_line: assert property (
    s_load(vid_std == vbi_pkg::STD_525P && tb_en &&
           line_num == vbi_pkg::LN_525P_TB)
    |=> kind_reg == KD_TB && len_reg == vbi_pkg::LEN_TB)
    else $error("525p type b not loaded on its line");
  a_cgms_625_low: assert property (
    s_load(vid_std == vbi_pkg::STD_625P && cgms_en &&
           line_num == vbi_pkg::LN_625P_CGMS)
    |=> len_reg == vbi_pkg::LEN_CGMS_625 &&
        shift_reg[13:0] == $past({cgms1_reg[5:0], cgms2_reg}))
    else $error("625p cgms word wrong");
  a_hd_cgms_lines: assert property (
    s_load(cgms_en && ((vid_std == vbi_pkg::STD_720P &&
           line_num == vbi_pkg::LN_720P_CGMS) ||
           (vid_std == vbi_pkg::STD_1080I &&
            line_num == vbi_pkg::LN_1080I_CGMS_B)))
    |=> kind_reg == KD_CGMS ##1 seq_reg == SQ_LEAD || !ce)
    else $error("hd cgms line missed");
  a_hd_tb_lines: assert property (
    s_load(tb_en && ((vid_std == vbi_pkg::STD_720P &&
           line_num == vbi_pkg::LN_720P_TB) ||
           (vid_std == vbi_pkg::STD_1080I &&
            line_num == vbi_pkg::LN_1080I_TB_A)))
    |=> kind_reg == KD_TB)
    else $error("hd type b line missed");
  a_cgms_crc_bits: assert property (
    s_load(sel_kind == KD_CGMS && sel_len == vbi_pkg::LEN_CGMS)
    |=> shift_reg[19:0] == ($past(prog_ctrl_reg[vbi_pkg::BIT_CGMS_CRC] ||
        sd_sig_reg[vbi_pkg::BIT_SD_CRC]) ?
        {$past(cgms_crc), $past(cgms_raw[13:0])} : $past(cgms_raw)))
    else $error("cgms check bits wrong");
  a_tb_crc_bits: assert property (
    s_load(sel_kind == KD_TB)
    |=> shift_reg[133:128] == ($past(typeb_reg[0][vbi_pkg::BIT_TB_CRC]) ?
        $past(tb_crc) : $past(tb_raw[133:128])))
    else $error("type b check bits wrong");
  a_wss_pal_only: assert property (
    s_load(!(vid_std == vbi_pkg::STD_PAL &&
             sd_sig_reg[vbi_pkg::BIT_WSS_EN]))
    |=> kind_reg != KD_WSS)
    else $error("signaling sent while not allowed");
  a_wss_video_back: assert property (
    ce && !line_start && kind_reg == KD_WSS &&
    line_cyc_reg == WSS_VIDEO_CYC - 14'h0001 |=> !pix_blank)
    else $error("video not restored on signaling line");
  a_wss_rsvd_zero: assert property (
    s_load(sel_kind == KD_WSS)
    |=> shift_reg[53 + vbi_pkg::WSS_RSVD_BIT] == 1'b0)
    else $error("reserved signaling bit set");
  a_cc_frame: assert property (
    s_load(sel_kind == KD_CC)
    |=> pix_blank && shift_reg[13:0] == vbi_pkg::CC_RUNIN &&
        shift_reg[19:14] == 6'h30)
    else $error("caption frame malformed");

endmodule
`default_nettype wire

// ==== vbi_pkg.sv ====
// Purpose: shared constants and types for the vertical blanking inserter
// Assumes: 250 MHz pixel-side clock, 8-bit subaddress register port
// Notes: bit periods and lead-in are placement defaults, tune per standard
package vbi_pkg;

  // output video standard reported by the timing generator
  typedef enum logic [2:0] {
    STD_NTSC, STD_PAL, STD_525P, STD_625P, STD_720P, STD_1080I
  } vbi_std_e;

  // subaddresses
  localparam logic [7:0] OFF_PROG_CTRL = 8'h32;
  localparam logic [7:0] OFF_CGMS0 = 8'h41;
  localparam logic [7:0] OFF_CGMS1 = 8'h42;
  localparam logic [7:0] OFF_CGMS2 = 8'h43;
  localparam logic [7:0] OFF_TYPEB_FIRST = 8'h5e;
  localparam logic [7:0] OFF_TYPEB_LAST = 8'h6e;
  localparam logic [7:0] OFF_CCX0 = 8'h91;
  localparam logic [7:0] OFF_CCX1 = 8'h92;
  localparam logic [7:0] OFF_CC0 = 8'h93;
  localparam logic [7:0] OFF_CC1 = 8'h94;
  localparam logic [7:0] OFF_SD_SIG = 8'h99;
  localparam logic [7:0] OFF_WSS0 = 8'h9a;
  localparam logic [7:0] OFF_WSS1 = 8'h9b;
  localparam logic [7:0] OFF_SD_BLANK = 8'ha1;
  localparam int TYPEB_BYTES = 17;
  localparam logic [7:0] REG_RST = 8'h00;

  // control bit positions
  localparam int BIT_CGMS_EN = 6;
  localparam int BIT_CGMS_CRC = 7;
  localparam int BIT_TB_EN = 0;
  localparam int BIT_TB_CRC = 1;
  localparam int BIT_SD_CRC = 4;
  localparam int BIT_WSS_EN = 7;
  localparam int BIT_WSS_BLANK = 7;
  localparam int WSS_RSVD_BIT = 7;

  // insertion lines
  localparam logic [10:0] LN_525P_CGMS = 11'h029;
  localparam logic [10:0] LN_525P_TB = 11'h028;
  localparam logic [10:0] LN_625P_CGMS = 11'h02b;
  localparam logic [10:0] LN_720P_CGMS = 11'h018;
  localparam logic [10:0] LN_1080I_CGMS_A = 11'h013;
  localparam logic [10:0] LN_1080I_CGMS_B = 11'h246;
  localparam logic [10:0] LN_720P_TB = 11'h017;
  localparam logic [10:0] LN_1080I_TB_A = 11'h012;
  localparam logic [10:0] LN_1080I_TB_B = 11'h245;
  localparam logic [10:0] LN_WSS = 11'h017;
  localparam logic [10:0] LN_CC_ODD = 11'h015;
  localparam logic [10:0] LN_CC_EVEN = 11'h11c;

  // frame lengths in transmitted elements
  localparam int FRAME_W = 160;
  localparam logic [7:0] LEN_CGMS = 8'h14;
  localparam logic [7:0] LEN_CGMS_625 = 8'h0e;
  localparam logic [7:0] LEN_TB = 8'h86;
  localparam logic [7:0] LEN_WSS = 8'h43;
  localparam logic [7:0] LEN_CC = 8'h34;

  // fixed patterns sent lsb first, then check preset and polynomial
  localparam logic [28:0] WSS_RUNIN = 29'h15555555;
  localparam logic [23:0] WSS_START = 24'h1e3c1f;
  localparam logic [13:0] CC_RUNIN = 14'h1555;
  localparam logic [5:0] CRC_PRESET = 6'h3f;
  localparam logic [5:0] CRC_POLY = 6'h03;

  // element periods in clocks and lead-in from line start
  localparam logic [7:0] PER_CGMS = 8'h40;
  localparam logic [7:0] PER_TB = 8'h10;
  localparam logic [7:0] PER_WSS = 8'h30;
  localparam logic [7:0] PER_CC = 8'h3f;
  localparam logic [13:0] START_CYC = 14'h0100;

  // video returns on the signaling line after this time
  localparam int CLK_NS = 4;
  localparam int WSS_VIDEO_NS = 42500;
  localparam int WSS_VIDEO_CYC = (WSS_VIDEO_NS + CLK_NS - 1) / CLK_NS;

endpackage

// ==== vbi_crc6.sv ====
// Purpose: six-bit check sequence over a message, x^6 + x + 1
// Assumes: message bit 0 is the first bit on the line
// Notes: purely combinational; out bit 0 is the first check bit sent
`timescale 1ns/1ps
`default_nettype none
module vbi_crc6 #(
  parameter int MSG_W = 14
) (
  // message in transmission order
  input wire logic [MSG_W-1:0] msg,
  // check bits, out[0] sent first
  output logic [5:0] crc
);

  // serial register stepped once per message bit
  always_comb
  begin
    logic fb;
    logic [5:0] r;
    fb = 1'b0;
    r = vbi_pkg::CRC_PRESET;
    for (int i = 0; i < MSG_W; i++)
    begin
      fb = msg[i] ^ r[5];
      r = {r[4:0], 1'b0} ^ (fb ? vbi_pkg::CRC_POLY : 6'h00);
    end
    for (int k = 0; k < 6; k++)
    begin
      crc[k] = r[5-k];
    end
  end

endmodule
`default_nettype wire

// ==== vbi_rx_model.sv ====
// Purpose: receiver that decodes the inserted element stream
// Assumes: element period given by the bench, lsb first on the line
// Notes: samples each element at its midpoint, clears on line start
`timescale 1ns/1ps
`default_nettype none
module vbi_rx_model (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // line timing and stream
  input wire logic line_start,
  input wire logic ins_active,
  input wire logic ins_bit,
  input wire logic [7:0] per,
  // decoded frame
  output logic [159:0] bits,
  output logic [7:0] nbits
);
  logic [7:0] phase_reg;
  ////////////////////////////////////////////////////////////////////////
  // midpoint sampler, first element lands in bit 0
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      phase_reg <= 8'h00;
      bits <= '0;
      nbits <= 8'h00;
    end
    else if (line_start)
    begin
      phase_reg <= 8'h00;
      bits <= '0;
      nbits <= 8'h00;
    end
    else if (ins_active)
    begin
      phase_reg <= (phase_reg == per - 8'h01) ? 8'h00 : phase_reg + 8'h01;
      if (phase_reg == (per >> 1) && nbits < 8'ha0)
      begin
        bits[nbits] <= ins_bit;
        nbits <= nbits + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// ==== testbench.sv ====
// Purpose: self-checking bench for the blanking line inserter
// Assumes: clock enable held high, receiver model decodes the stream
// Notes: signaling video return shortened to 400 cycles
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk, nrst, we, re, ls, odd, cce, act, ib, pb;
  logic [7:0] addr, wd, rdata, per, nb;
  logic [10:0] ln;
  logic [159:0] bits, e;
  vbi_pkg::vbi_std_e std;
  int num_errors = 0;
  int cmp_count = 0;
  // clock
  initial
  begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end
  vbi_data_inserter #(.WSS_VIDEO_CYC(14'h0190)) DUT (.clk(clk), .nrst(nrst),
    .ce(1'h1), .reg_we(we), .reg_re(re), .reg_addr(addr), .reg_wdata(wd),
    .reg_rdata(rdata), .vid_std(std), .line_start(ls), .line_num(ln),
    .field_odd(odd), .cc_enable(cce), .ins_active(act), .ins_bit(ib),
    .pix_blank(pb));
  vbi_rx_model rx (.clk(clk), .nrst(nrst), .line_start(ls),
    .ins_active(act), .ins_bit(ib), .per(per), .bits(bits), .nbits(nb));
  ////////////////////////////////////////////////////////////////////////
  task chk(input string n, input logic [159:0] x, input logic [159:0] g);
    cmp_count++;
    if (g !== x)
    begin
      num_errors++;
      $display("CHECK FAILED %s exp %h got %h", n, x, g);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    we = 1'h1; addr = a; wd = d;
    @(negedge clk);
    we = 1'h0;
  endtask
  task line(input vbi_pkg::vbi_std_e s, input logic [10:0] n,
    input logic o, input int cyc);
    @(negedge clk);
    std = s; ln = n; odd = o; ls = 1'h1;
    @(negedge clk);
    ls = 1'h0;
    repeat (cyc) @(negedge clk);
  endtask
  // check bits over the first n bits, result bit 0 sent first
  function automatic logic [5:0] crcn(input logic [127:0] m, input int n);
    logic [5:0] r;
    logic [5:0] c;
    r = 6'h3f;
    for (int i = 0; i < n; i++)
      r = {r[4:0], 1'h0} ^ ((m[i] ^ r[5]) ? 6'h03 : 6'h00);
    for (int k = 0; k < 6; k++)
      c[k] = r[5 - k];
    return c;
  endfunction
  function automatic logic [19:0] crc20(input logic [13:0] m);
    return {crcn(128'(m), 14), m};
  endfunction
  ////////////////////////////////////////////////////////////////////////
  // register port, then 720p copy control with and without check bits
  task s_cgms;
    wr(8'h32, 8'h40);
    @(negedge clk); re = 1'h1; addr = 8'h32;
    @(negedge clk); re = 1'h0; addr = 8'h50;
    @(negedge clk); chk("ctrl read", 160'(8'h40), 160'(rdata));
    re = 1'h1;
    @(negedge clk); re = 1'h0;
    @(negedge clk); chk("unmapped read", 160'h0, 160'(rdata));
    wr(8'h41, 8'h0a); wr(8'h42, 8'h5c); wr(8'h43, 8'ha3);
    per = 8'h40;
    line(vbi_pkg::STD_720P, 11'h018, 1'h0, 1600);
    chk("cgms raw", 160'({4'ha, 8'h5c, 8'ha3}), bits);
    chk("cgms len", 160'(8'h14), 160'(nb));
    wr(8'h32, 8'hc0);
    line(vbi_pkg::STD_720P, 11'h018, 1'h0, 1600);
    chk("cgms crc", 160'(crc20(14'h1ca3)), bits);
    wr(8'h32, 8'h40);
    line(vbi_pkg::STD_625P, 11'h02b, 1'h0, 1600);
    chk("625p word", 160'(14'h1ca3), bits);
    chk("625p len", 160'(8'h0e), 160'(nb));
  endtask
  // 1080i line selection, then type b packet on 720p
  task s_hd;
    logic [10:0] l [4];
    l = '{11'h013, 11'h246, 11'h012, 11'h018};
    for (int i = 0; i < 4; i++)
    begin
      line(vbi_pkg::STD_1080I, l[i], 1'h0, 1600);
      chk("1080i len", 160'(i < 2 ? 8'h14 : 8'h00), 160'(nb));
    end
    per = 8'h10;
    e = 160'(6'h25);
    wr(8'h5e, 8'h95);
    for (int k = 0; k < 16; k++)
    begin
      wr(8'h5f + 8'(k), 8'(k * 29 + 3));
      e[6 + 8 * k +: 8] = 8'(k * 29 + 3);
    end
    line(vbi_pkg::STD_720P, 11'h017, 1'h0, 2500);
    chk("typeb raw", e, bits);
    chk("typeb len", 160'(8'h86), 160'(nb));
    line(vbi_pkg::STD_1080I, 11'h245, 1'h0, 2500);
    chk("typeb 1080i len", 160'(8'h86), 160'(nb));
    line(vbi_pkg::STD_525P, 11'h028, 1'h0, 2500);
    chk("typeb 525p len", 160'(8'h86), 160'(nb));
    wr(8'h5e, 8'h97);
    line(vbi_pkg::STD_720P, 11'h017, 1'h0, 2500);
    chk("typeb crc", 160'(crcn(e[127:0], 128)), 160'(bits[133:128]));
    chk("typeb crc body", 160'(e[127:0]), 160'(bits[127:0]));
    per = 8'h40;
    line(vbi_pkg::STD_525P, 11'h029, 1'h0, 1600);
    chk("cgms 525p", 160'({4'ha, 8'h5c, 8'ha3}), bits);
    chk("cgms 525p len", 160'(8'h14), 160'(nb));
  endtask
  // signaling: disabled, enabled, blanked
  task s_wss;
    wr(8'h9a, 8'hd5); wr(8'h9b, 8'h2b);
    per = 8'h30;
    line(vbi_pkg::STD_PAL, 11'h017, 1'h0, 3600);
    chk("wss off len", 160'h0, 160'(nb));
    wr(8'h99, 8'h80);
    line(vbi_pkg::STD_PAL, 11'h017, 1'h0, 3600);
    chk("wss len", 160'(8'h43), 160'(nb));
    chk("wss word", 160'({6'h2b, 8'h55}), 160'(bits[66:53]));
    chk("wss video back", 160'h0, 160'(pb));
    wr(8'ha1, 8'h80);
    line(vbi_pkg::STD_PAL, 11'h017, 1'h0, 3);
    chk("wss blanked", 160'h1, 160'(pb));
    repeat (3600) @(negedge clk);
    chk("wss blank len", 160'h0, 160'(nb));
  endtask
  // caption line with doubled half bits and generated parity
  task cc_line(input logic [10:0] n, input logic o, input logic [7:0] a,
    input logic [7:0] b);
    logic [15:0] d;
    d = {~^b[6:0], b[6:0], ~^a[6:0], a[6:0]};
    e = 160'h0;
    for (int i = 0; i < 14; i++)
      e[i] = ~i[0];
    e[18] = 1'h1;
    e[19] = 1'h1;
    for (int i = 0; i < 16; i++)
      e[20 + 2 * i +: 2] = {d[i], d[i]};
    line(vbi_pkg::STD_NTSC, n, o, 3);
    chk("cc pixel blank", 160'h1, 160'(pb));
    repeat (3600) @(negedge clk);
    chk("cc frame", e, bits);
  endtask
  task s_cc;
    wr(8'h93, 8'h41); wr(8'h94, 8'he2);
    wr(8'h91, 8'h13); wr(8'h92, 8'h7f);
    cce = 1'h1;
    per = 8'h3f;
    cc_line(11'h015, 1'h1, 8'h41, 8'he2);
    cc_line(11'h11c, 1'h0, 8'h13, 8'h7f);
    wr(8'h93, 8'h00);
    wr(8'h94, 8'h00);
    cc_line(11'h015, 1'h1, 8'h00, 8'h00);
  endtask
  task conclude;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    nrst = 1'h0; we = 1'h0; re = 1'h0; ls = 1'h0; odd = 1'h0; cce = 1'h0;
    addr = 8'h00; wd = 8'h00; ln = 11'h000; per = 8'h40;
    std = vbi_pkg::STD_NTSC;
    repeat (8) @(negedge clk);
    nrst = 1'h1;
    s_cgms;
    s_hd;
    s_wss;
    s_cc;
    conclude;
  end
  // watchdog
  initial
  begin
    #300000;
    num_errors++;
    $display("watchdog expired");
    conclude;
  end
endmodule
`default_nettype wire
